// ===== verilog/port_gate_pkg.sv
// Contract
// - A set gating bit clocks and enables its port; a clear bit stops and disables it.
// - Any access to a port whose clock is gated off is answered with a bus fault.
// - Reset loads the whole deep-sleep gating register with all zeros.
// - The deep-sleep gating register decodes at offset 0x128 from base 0x400FE000.
// - The deep-sleep pattern is applied only in deep-sleep; run and sleep have their own.
// - Sleep-mode gating patterns apply only while the auto gating select bit is set.
// - Bit 0 is the read-write clock enable of port A, reset value 0.
package port_gate_pkg;

  // ********************************
  // Sizes and addresses
  // ********************************
  localparam int PORT_COUNT = 8;
  localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;
  localparam logic [11:0] CLK_CFG_OFS = 12'h060;
  localparam logic [11:0] RUN_GATE_OFS = 12'h100;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h110;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h128;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h140;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h144;
  localparam logic [11:0] MODE_STAT_OFS = 12'h148;

  // ********************************
  // Fields and reset values
  // ********************************
  localparam int AUTO_GATE_BIT = 0;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic AUTO_GATE_RESET = 1'b0;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_DEEP = 3'b100
  } power_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] idx;
  } port_req_t;

  typedef struct packed {
    logic done;
    logic fault;
    logic [2:0] idx;
  } port_rsp_t;

  // ********************************
  // Helpers
  // ********************************
  function automatic logic reg_hit(input logic [31:0] addr, input logic [11:0] ofs);
    return addr == (SYSCTL_BASE + {20'h00000, ofs});
  endfunction

  function automatic logic [7:0] port_onehot(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction

endpackage

// ===== verilog/port_access_guard.sv
`timescale 1ns/10ps
module port_access_guard
  import port_gate_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire port_req_t req_in,
  input wire logic [7:0] enable_in,
  output port_rsp_t rsp_out
);

  // ********************************
  // Access answer
  // ********************************
  port_rsp_t rsp_q;
  port_rsp_t rsp_d;

  always_comb begin
    rsp_d.done = req_in.valid;
    rsp_d.idx = req_in.idx;
    rsp_d.fault = req_in.valid & ~|(port_onehot(req_in.idx) & enable_in);
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp_out = rsp_q;

endmodule

// ===== verilog/port_gating_ctrl.sv
`timescale 1ns/10ps
module port_gating_ctrl
  import port_gate_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic SLEEP_IN,
  input wire logic DEEP_SLEEP_IN,
  input wire logic PORT_REQ_IN,
  input wire logic PORT_WRITE_IN,
  input wire logic [2:0] PORT_IDX_IN,
  output logic PORT_DONE_OUT,
  output logic PORT_FAULT_OUT,
  output logic [7:0] PORT_CLK_EN_OUT,
  output logic [2:0] MODE_OUT,
  output logic IRQ_OUT
);

  // ********************************
  // Declarations
  // ********************************
  logic access_w;
  logic commit_w;
  logic mapped_w;
  logic wr_byte0_w;
  logic [31:0] rd_mux_w;

  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  logic [7:0] run_gate_q;
  logic [7:0] run_gate_d;
  logic [7:0] sleep_gate_q;
  logic [7:0] sleep_gate_d;
  logic [7:0] deep_gate_q;
  logic [7:0] deep_gate_d;
  logic auto_gate_q;
  logic auto_gate_d;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_stat_d;
  logic [7:0] irq_mask_q;
  logic [7:0] irq_mask_d;
  logic [7:0] fault_evt_w;
  logic [7:0] stat_clr_w;
  logic irq_q;
  logic irq_d;

  power_mode_t mode_q;
  power_mode_t mode_d;
  logic [7:0] en_q;
  logic [7:0] en_d;

  port_req_t port_req_w;
  port_rsp_t port_rsp_w;

  // ********************************
  // Bus decode
  // ********************************
  assign access_w = PSEL_IN & PENABLE_IN;
  assign commit_w = access_w & pready_q;
  assign wr_byte0_w = commit_w & PWRITE_IN & PSTRB_IN[0] & mapped_w;

  always_comb begin
    mapped_w = 1'b1;
    rd_mux_w = 32'h00000000;
    if (reg_hit(PADDR_IN, DEEP_GATE_OFS)) begin
      rd_mux_w = {24'h000000, deep_gate_q};
    end else if (reg_hit(PADDR_IN, RUN_GATE_OFS)) begin
      rd_mux_w = {24'h000000, run_gate_q};
    end else if (reg_hit(PADDR_IN, SLEEP_GATE_OFS)) begin
      rd_mux_w = {24'h000000, sleep_gate_q};
    end else if (reg_hit(PADDR_IN, CLK_CFG_OFS)) begin
      rd_mux_w = {31'h0000000, auto_gate_q};
    end else if (reg_hit(PADDR_IN, IRQ_STAT_OFS)) begin
      rd_mux_w = {24'h000000, irq_stat_q};
    end else if (reg_hit(PADDR_IN, IRQ_MASK_OFS)) begin
      rd_mux_w = {24'h000000, irq_mask_q};
    end else if (reg_hit(PADDR_IN, MODE_STAT_OFS)) begin
      rd_mux_w = {21'h00000, mode_q, en_q};
    end else begin
      mapped_w = 1'b0;
    end
  end

  // ********************************
  // Bus answer
  // ********************************
  always_comb begin
    pready_d = access_w & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d = 32'h00000000;
    if (access_w && !pready_q) begin
      pslverr_d = ~mapped_w;
      if (!PWRITE_IN) begin
        prdata_d = rd_mux_w;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ********************************
  // Registers
  // ********************************
  always_comb begin
    run_gate_d = run_gate_q;
    sleep_gate_d = sleep_gate_q;
    deep_gate_d = deep_gate_q;
    auto_gate_d = auto_gate_q;
    irq_mask_d = irq_mask_q;
    stat_clr_w = 8'h00;
    if (wr_byte0_w) begin
      // ports A to H, upper bits dropped
      if (reg_hit(PADDR_IN, DEEP_GATE_OFS)) begin
        deep_gate_d = PWDATA_IN[7:0];
      end
      if (reg_hit(PADDR_IN, RUN_GATE_OFS)) begin
        run_gate_d = PWDATA_IN[7:0];
      end
      if (reg_hit(PADDR_IN, SLEEP_GATE_OFS)) begin
        sleep_gate_d = PWDATA_IN[7:0];
      end
      if (reg_hit(PADDR_IN, CLK_CFG_OFS)) begin
        auto_gate_d = PWDATA_IN[AUTO_GATE_BIT];
      end
      if (reg_hit(PADDR_IN, IRQ_MASK_OFS)) begin
        irq_mask_d = PWDATA_IN[7:0];
      end
      if (reg_hit(PADDR_IN, IRQ_STAT_OFS)) begin
        stat_clr_w = PWDATA_IN[7:0];
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      run_gate_q <= GATE_RESET;
      sleep_gate_q <= GATE_RESET;
      deep_gate_q <= GATE_RESET;
      auto_gate_q <= AUTO_GATE_RESET;
      irq_mask_q <= IRQ_RESET;
    end else begin
      run_gate_q <= run_gate_d;
      sleep_gate_q <= sleep_gate_d;
      deep_gate_q <= deep_gate_d;
      auto_gate_q <= auto_gate_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // ********************************
  // Power mode tracking
  // ********************************
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RUN: begin
        if (SLEEP_IN) begin
          mode_d = DEEP_SLEEP_IN ? MODE_DEEP : MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (!SLEEP_IN) begin
          mode_d = MODE_RUN;
        end else if (DEEP_SLEEP_IN) begin
          mode_d = MODE_DEEP;
        end
      end
      MODE_DEEP: begin
        if (!SLEEP_IN) begin
          mode_d = MODE_RUN;
        end else if (!DEEP_SLEEP_IN) begin
          mode_d = MODE_SLEEP;
        end
      end
      default: begin
        mode_d = MODE_RUN;
      end
    endcase
  end

  // ********************************
  // Effective port enables
  // ********************************
  always_comb begin
    en_d = run_gate_q;
    if (auto_gate_q) begin
      if (mode_q == MODE_DEEP) begin
        en_d = deep_gate_q;
      end else if (mode_q == MODE_SLEEP) begin
        en_d = sleep_gate_q;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      mode_q <= MODE_RUN;
      en_q <= GATE_RESET;
    end else begin
      mode_q <= mode_d;
      en_q <= en_d;
    end
  end

  // ********************************
  // Port access check
  // ********************************
  assign port_req_w = '{valid: PORT_REQ_IN, write: PORT_WRITE_IN, idx: PORT_IDX_IN};

  port_access_guard u_guard (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .req_in(port_req_w),
    .enable_in(en_q),
    .rsp_out(port_rsp_w)
  );

  // ********************************
  // Fault interrupt
  // ********************************
  always_comb begin
    fault_evt_w = 8'h00;
    if (port_rsp_w.done && port_rsp_w.fault) begin
      fault_evt_w = port_onehot(port_rsp_w.idx);
    end
    irq_stat_d = (irq_stat_q & ~stat_clr_w) | fault_evt_w;
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      irq_stat_q <= IRQ_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign PORT_DONE_OUT = port_rsp_w.done;
  assign PORT_FAULT_OUT = port_rsp_w.fault;
  assign PORT_CLK_EN_OUT = en_q;
  assign MODE_OUT = mode_q;
  assign IRQ_OUT = irq_q;

endmodule

// ===== verification/port_gate_checker_assertions.sv
`timescale 1ns/10ps
module port_gate_checker
  import port_gate_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic SLEEP_IN,
  input wire logic DEEP_SLEEP_IN,
  input wire logic PORT_REQ_IN,
  input wire logic [2:0] PORT_IDX_IN,
  input wire logic PORT_DONE_OUT,
  input wire logic PORT_FAULT_OUT,
  input wire logic [7:0] PORT_CLK_EN_OUT,
  input wire logic [2:0] MODE_OUT
);
  // *********
  // Checks
  // *********
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  logic miss_q;
  wire wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  always_ff @(posedge CLK_IN) begin
    miss_q <= !PORT_CLK_EN_OUT[PORT_IDX_IN];
  end
  sequence s_deep;
    PSEL_IN && PENABLE_IN && !PREADY_OUT && PADDR_IN == SYSCTL_BASE + {20'h00000, DEEP_GATE_OFS};
  endsequence
  property p_done;
    PORT_REQ_IN |=> PORT_DONE_OUT;
  endproperty
  a_done: assert property (p_done) else $error("port done missing");
  property p_fault;
    PORT_REQ_IN |=> PORT_FAULT_OUT == miss_q;
  endproperty
  a_fault: assert property (p_fault) else $error("port fault wrong");
  property p_rst;
    disable iff (1'b0) !RESET_N_IN |=> PORT_CLK_EN_OUT == 8'h00 && MODE_OUT == MODE_RUN;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_deep;
    s_deep |=> PREADY_OUT && !PSLVERR_OUT;
  endproperty
  a_deep: assert property (p_deep) else $error("gate register not decoded");
  property p_rsvd;
    s_deep ##0 !PWRITE_IN |=> PRDATA_OUT[31:8] == 24'h000000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper bits not zero");
  property p_hold;
    (!wr && $stable(MODE_OUT)) [*3] |-> $stable(PORT_CLK_EN_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("enables moved");
  property p_mdeep;
    SLEEP_IN && DEEP_SLEEP_IN |=> MODE_OUT == MODE_DEEP;
  endproperty
  a_mdeep: assert property (p_mdeep) else $error("deep mode wrong");
  property p_msleep;
    SLEEP_IN && !DEEP_SLEEP_IN |=> MODE_OUT == MODE_SLEEP;
  endproperty
  a_msleep: assert property (p_msleep) else $error("sleep mode wrong");
  property p_mrun;
    !SLEEP_IN |=> MODE_OUT == MODE_RUN;
  endproperty
  a_mrun: assert property (p_mrun) else $error("run mode wrong");
endmodule

bind port_gating_ctrl port_gate_checker chk_i (
  .CLK_IN(CLK_IN),
  .RESET_N_IN(RESET_N_IN),
  .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN),
  .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT),
  .SLEEP_IN(SLEEP_IN),
  .DEEP_SLEEP_IN(DEEP_SLEEP_IN),
  .PORT_REQ_IN(PORT_REQ_IN),
  .PORT_IDX_IN(PORT_IDX_IN),
  .PORT_DONE_OUT(PORT_DONE_OUT),
  .PORT_FAULT_OUT(PORT_FAULT_OUT),
  .PORT_CLK_EN_OUT(PORT_CLK_EN_OUT),
  .MODE_OUT(MODE_OUT)
);

// ===== verification/tb.sv
`timescale 1ns/10ps
module tb;
  import port_gate_pkg::*;
  logic CLK_IN = '0, RESET_N_IN = '0, PSEL_IN = '0, PENABLE_IN = '0, PWRITE_IN = '0;
  logic [31:0] PADDR_IN = '0, PWDATA_IN = '0, PRDATA_OUT, rd;
  logic [3:0] PSTRB_IN = 4'hF;
  logic PREADY_OUT, PSLVERR_OUT, SLEEP_IN = '0, DEEP_SLEEP_IN = '0, PORT_REQ_IN = '0;
  logic PORT_WRITE_IN = '0, PORT_DONE_OUT, PORT_FAULT_OUT, IRQ_OUT, er;
  logic [2:0] PORT_IDX_IN = '0, MODE_OUT;
  logic [7:0] PORT_CLK_EN_OUT, e;
  logic [7:0] g [3];
  logic [11:0] go [3] = '{RUN_GATE_OFS, SLEEP_GATE_OFS, DEEP_GATE_OFS};
  power_mode_t md [3] = '{MODE_RUN, MODE_SLEEP, MODE_DEEP};
  int num_errors = 0, checks_done = 0, cyc = 0;
  port_gating_ctrl dut (
    .CLK_IN(CLK_IN),
    .RESET_N_IN(RESET_N_IN),
    .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN),
    .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN),
    .PSTRB_IN(PSTRB_IN),
    .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT),
    .SLEEP_IN(SLEEP_IN),
    .DEEP_SLEEP_IN(DEEP_SLEEP_IN),
    .PORT_REQ_IN(PORT_REQ_IN),
    .PORT_WRITE_IN(PORT_WRITE_IN),
    .PORT_IDX_IN(PORT_IDX_IN),
    .PORT_DONE_OUT(PORT_DONE_OUT),
    .PORT_FAULT_OUT(PORT_FAULT_OUT),
    .PORT_CLK_EN_OUT(PORT_CLK_EN_OUT),
    .MODE_OUT(MODE_OUT),
    .IRQ_OUT(IRQ_OUT)
  );
  // *********
  // Helpers
  // *********
  initial forever #50 CLK_IN = ~CLK_IN;
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      num_errors++;
      $display("[ERR] %0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] o, input logic [31:0] d);
    @(posedge CLK_IN);
    PSEL_IN <= 1'h1;
    PWRITE_IN <= w;
    PADDR_IN <= SYSCTL_BASE + {20'h00000, o};
    PWDATA_IN <= d;
    @(posedge CLK_IN);
    PENABLE_IN <= 1'h1;
    do @(posedge CLK_IN); while (PREADY_OUT !== 1'h1);
    rd = PRDATA_OUT;
    er = PSLVERR_OUT;
    PSEL_IN <= 1'h0;
    PENABLE_IN <= 1'h0;
  endtask
  task automatic port(input logic [2:0] i, input logic f);
    @(posedge CLK_IN);
    PORT_REQ_IN <= 1'h1;
    PORT_IDX_IN <= i;
    PORT_WRITE_IN <= 1'($urandom);
    @(posedge CLK_IN);
    PORT_REQ_IN <= 1'h0;
    @(posedge CLK_IN);
    chk(PORT_DONE_OUT, 1);
    chk(PORT_FAULT_OUT, f);
  endtask
  function automatic logic [7:0] eff(input power_mode_t m, input logic a);
    return (!a || m == MODE_RUN) ? g[0] : (m == MODE_SLEEP ? g[1] : g[2]);
  endfunction
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge CLK_IN) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  initial begin
    void'($urandom(24));
    repeat (12) @(posedge CLK_IN);
    RESET_N_IN <= 1'h1;
    foreach (go[k]) begin
      apb(0, go[k], 0);
      chk(rd, 0);
    end
    for (int i = 0; i < 8; i++) port(i, 1);
    apb(0, 12'h124, 0);
    chk(er, 1);
    for (int n = 0; n < 4; n++) begin
      foreach (g[k]) begin
        g[k] = n == 0 ? 8'h01 : (n == 1 ? 8'h80 : 8'($urandom));
        apb(1, go[k], {24'($urandom), g[k]});
        apb(0, go[k], 0);
        chk(rd, {24'h000000, g[k]});
        chk(er, 0);
      end
      apb(1, CLK_CFG_OFS, {31'h0, n[0]});
      foreach (md[k]) begin
        @(posedge CLK_IN);
        SLEEP_IN <= md[k] != MODE_RUN;
        DEEP_SLEEP_IN <= md[k] == MODE_DEEP;
        repeat (3) @(posedge CLK_IN);
        e = eff(md[k], n[0]);
        chk(MODE_OUT, md[k]);
        chk(PORT_CLK_EN_OUT, e);
        apb(0, MODE_STAT_OFS, 0);
        chk(rd, {21'h00000, md[k], e});
        for (int i = 0; i < 8; i++) port(i, !e[i]);
      end
    end
    apb(1, CLK_CFG_OFS, 0);
    apb(1, RUN_GATE_OFS, 0);
    apb(1, IRQ_STAT_OFS, 32'hFF);
    apb(1, IRQ_MASK_OFS, 32'h04);
    apb(0, IRQ_MASK_OFS, 0);
    chk(rd, 32'h04);
    port(3, 1);
    repeat (2) @(posedge CLK_IN);
    chk(IRQ_OUT, 0);
    port(2, 1);
    repeat (2) @(posedge CLK_IN);
    chk(IRQ_OUT, 1);
    apb(0, IRQ_STAT_OFS, 0);
    chk(rd, 32'h0C);
    apb(1, IRQ_STAT_OFS, 32'h04);
    repeat (2) @(posedge CLK_IN);
    chk(IRQ_OUT, 0);
    RESET_N_IN <= 1'h0;
    repeat (2) @(posedge CLK_IN);
    RESET_N_IN <= 1'h1;
    apb(0, DEEP_GATE_OFS, 0);
    chk(rd, 0);
    end_of_test;
  end
endmodule
